// [design/ifc_edge_sync.sv]
`timescale 1ns/1ps
module ifc_edge_sync (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise
);
	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic last_q, last_d;

	// next values: only sync_q reads the first stage
	always_comb begin
		meta_d = i_pin;
		sync_d = meta_q;
		last_d = sync_q;
	end

	// two-flop synchroniser plus one stage for edge detection
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	// one-cycle pulse per rising edge, from synchronised stages only
	assign o_level = sync_q;
	assign o_rise = sync_q & ~last_q;
endmodule : ifc_edge_sync

// [design/ifc_if_counter.sv]
`timescale 1ns/1ps
//Contract
//- a 20-bit counter counts rising edges of the if input
//- gate time picked from 1, 4, 16 or 64 ms; counts only while open
//- the full 20-bit result is readable by the processor
//- with if counting unused, the counter serves as a timer
//- split mode makes two independent counters of 12 and 8 bits
//- in split mode 12-bit counts pin one, 8-bit counts pin two
//- pin selection, mode and counter controls are all set by software
//- the if pin can serve as a plain digital input port instead
//- if input from 0.35 to 12 MHz is counted without losing edges
//- results let software compare the measured if against expected values
module ifc_if_counter import ifc_pkg::*; #(
	parameter int unsigned P_GATE_BASE_CYCLES = GATE_BASE_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_intermediate_freq_input,
	input wire logic i_wide_counter_pulse_input,
	input wire logic i_narrow_counter_pulse_input,
	input wire logic [1:0] i_mode,
	input wire logic [1:0] i_gate_sel,
	input wire logic i_if_as_port,
	input wire logic i_start,
	input wire logic i_stop,
	input wire logic i_result_ack,
	output logic [CNT_W-1:0] o_count,
	output logic o_done,
	output logic o_gate_open,
	output logic o_general_input_port_a
);
	// gate length in clock cycles: base shifted by two per select step
	function automatic logic [GATE_CNT_W-1:0] ifc_gate_limit(input logic [1:0] sel);
		ifc_gate_limit = GATE_CNT_W'(P_GATE_BASE_CYCLES) << {sel, 1'b0};
	endfunction : ifc_gate_limit

	logic if_level, if_rise;
	logic wide_rise, narrow_rise;

	// every pin passes two flops before any logic sees it
	ifc_edge_sync u_if_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin(i_intermediate_freq_input),
		.o_level(if_level),
		.o_rise(if_rise)
	);

	ifc_edge_sync u_wide_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin(i_wide_counter_pulse_input),
		.o_level(),
		.o_rise(wide_rise)
	);

	ifc_edge_sync u_narrow_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin(i_narrow_counter_pulse_input),
		.o_level(),
		.o_rise(narrow_rise)
	);

	ifc_state_t state_q, state_d;
	ifc_mode_t mode_q, mode_d;
	logic [1:0] gsel_q, gsel_d;
	logic [GATE_CNT_W-1:0] gate_cnt_q, gate_cnt_d;
	logic [TICK_CNT_W-1:0] tick_cnt_q, tick_cnt_d;
	logic [CNT_W-1:0] count_q, count_d;
	logic done_q, done_d;
	logic gate_q, gate_d;
	logic port_q, port_d;
	logic start_ok, gate_end, tick, close_now;
	logic [WIDE_W-1:0] wide_field;
	logic [NARROW_W-1:0] narrow_field;

	// start is refused while a measurement runs
	assign start_ok = i_start && (state_q != IFC_ST_RUN);
	assign gate_end = (mode_q == IFC_MODE_IF) &&
		(gate_cnt_q == ifc_gate_limit(gsel_q) - GATE_CNT_ONE);
	assign tick = (tick_cnt_q == TICK_LAST);
	assign close_now = (state_q == IFC_ST_RUN) && (gate_end || i_stop);
	assign wide_field = count_q[WIDE_LSB +: WIDE_W];
	assign narrow_field = count_q[NARROW_LSB +: NARROW_W];

	// sequencer: idle, run with gate open, hold result
	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		gsel_d = gsel_q;
		if (start_ok) begin
			state_d = IFC_ST_RUN;
			mode_d = ifc_mode_t'(i_mode);
			gsel_d = i_gate_sel;
		end else begin
			case (state_q)
				IFC_ST_RUN: begin
					if (close_now) begin
						state_d = IFC_ST_HOLD;
					end
				end
				IFC_ST_HOLD: begin
					if (i_result_ack && !done_q) begin
						state_d = IFC_ST_HOLD;
					end
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end
	end

	// gate and timer-tick counters reload on every start
	always_comb begin
		gate_cnt_d = gate_cnt_q;
		tick_cnt_d = tick_cnt_q;
		if (start_ok) begin
			gate_cnt_d = GATE_CNT_RESET;
			tick_cnt_d = TICK_CNT_RESET;
		end else if (state_q == IFC_ST_RUN) begin
			gate_cnt_d = gate_cnt_q + GATE_CNT_ONE;
			tick_cnt_d = tick ? TICK_CNT_RESET : tick_cnt_q + TICK_CNT_ONE;
		end
	end

	// count path; an edge in the closing cycle is still taken
	always_comb begin
		count_d = count_q;
		if (start_ok) begin
			count_d = CNT_RESET;
		end else if (state_q == IFC_ST_RUN) begin
			case (mode_q)
				IFC_MODE_IF: begin
					// port mode keeps the pin away from the counter
					if (if_rise && !i_if_as_port) begin
						count_d = count_q + CNT_ONE;
					end
				end
				IFC_MODE_TIMER: begin
					if (tick) begin
						count_d = count_q + CNT_ONE;
					end
				end
				IFC_MODE_SPLIT: begin
					// fields wrap on their own, no carry between them
					count_d[WIDE_LSB +: WIDE_W] = wide_field + (wide_rise ? WIDE_ONE :
						12'h000);
					count_d[NARROW_LSB +: NARROW_W] = narrow_field +
						(narrow_rise ? NARROW_ONE : 8'h00);
				end
				default: begin
					count_d = count_q;
				end
			endcase
		end
	end

	// done flag: set at gate close wins over a read in the same cycle
	always_comb begin
		done_d = done_q;
		if (close_now) begin
			done_d = 1'b1;
		end else if (start_ok || i_result_ack) begin
			done_d = 1'b0;
		end
		gate_d = (state_d == IFC_ST_RUN);
		port_d = if_level;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= IFC_ST_IDLE;
			mode_q <= IFC_MODE_IF;
			gsel_q <= GSEL_1MS;
			gate_cnt_q <= GATE_CNT_RESET;
			tick_cnt_q <= TICK_CNT_RESET;
			count_q <= CNT_RESET;
			done_q <= 1'b0;
			gate_q <= 1'b0;
			port_q <= 1'b0;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			gsel_q <= gsel_d;
			gate_cnt_q <= gate_cnt_d;
			tick_cnt_q <= tick_cnt_d;
			count_q <= count_d;
			done_q <= done_d;
			gate_q <= gate_d;
			port_q <= port_d;
		end
	end

	// result is the live register so software can compare it at any time
	assign o_count = count_q;
	assign o_done = done_q;
	assign o_gate_open = gate_q;
	assign o_general_input_port_a = port_q;

	// helper: cycles the gate has stood open, read only by checks
	logic [GATE_CNT_W-1:0] open_len_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			open_len_q <= GATE_CNT_RESET;
		end else begin
			open_len_q <= gate_q ? open_len_q + GATE_CNT_ONE : GATE_CNT_RESET;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	// start clears count and opens gate on the next edge
	chk_start_clears_count: assert property (
		start_ok |=> (o_count == CNT_RESET) && o_gate_open && !o_done
	) else $error("start did not clear count and open gate");

	// the if gate stands open for exactly the selected length
	chk_gate_exact_length: assert property (
		($fell(o_gate_open) && mode_q == IFC_MODE_IF && !$past(i_stop))
			|-> (open_len_q == ifc_gate_limit(gsel_q))
	) else $error("if gate length differs from selection");

	// after close the result holds still until the next start
	chk_hold_result_stable: assert property (
		(state_q == IFC_ST_HOLD && !start_ok) |=> $stable(o_count)
	) else $error("held result changed");

	// done stays up until a read or new start
	chk_done_until_read: assert property (
		(o_done && !i_result_ack && !i_start) |=> o_done
	) else $error("done dropped without a read");

	// closing the gate raises done and lowers gate together
	chk_close_sets_done: assert property (
		close_now |=> o_done && !o_gate_open
	) else $error("gate close did not set done");

	// each synchronised if edge adds one while counting
	chk_if_edge_counted: assert property (
		(state_q == IFC_ST_RUN && mode_q == IFC_MODE_IF && if_rise && !i_if_as_port
			&& !start_ok) |=> (o_count == $past(o_count) + CNT_ONE)
	) else $error("if edge not counted");

	// port use keeps the counter frozen in if mode
	chk_port_blocks_count: assert property (
		(state_q == IFC_ST_RUN && mode_q == IFC_MODE_IF && i_if_as_port && !start_ok)
			|=> $stable(o_count)
	) else $error("counter moved while pin used as port");

	// split narrow field follows pin two alone
	chk_split_narrow_field: assert property (
		(state_q == IFC_ST_RUN && mode_q == IFC_MODE_SPLIT && !start_ok)
			|=> (o_count[NARROW_LSB +: NARROW_W] == $past(narrow_field) +
			($past(narrow_rise) ? NARROW_ONE : 8'h00))
	) else $error("narrow split counter wrong");

	// split wide field follows pin one alone
	chk_split_wide_field: assert property (
		(state_q == IFC_ST_RUN && mode_q == IFC_MODE_SPLIT && !start_ok)
			|=> (o_count[WIDE_LSB +: WIDE_W] == $past(wide_field) +
			($past(wide_rise) ? WIDE_ONE : 12'h000))
	) else $error("wide split counter wrong");

	// timer advances only on a tick
	chk_timer_on_tick: assert property (
		(state_q == IFC_ST_RUN && mode_q == IFC_MODE_TIMER && !tick && !start_ok)
			|=> $stable(o_count)
	) else $error("timer advanced without tick");

	cov_if_measure_done: cover property (
		$fell(o_gate_open) && mode_q == IFC_MODE_IF && !$past(i_stop)
	);
	cov_split_both_edges: cover property (
		state_q == IFC_ST_RUN && mode_q == IFC_MODE_SPLIT && wide_rise && narrow_rise
	);
	cov_timer_stopped: cover property (
		close_now && mode_q == IFC_MODE_TIMER
	);
	cov_read_meets_close: cover property (
		close_now && i_result_ack
	);
endmodule : ifc_if_counter

// [pkg/ifc_pkg.sv]
package ifc_pkg;
	// counter geometry
	localparam int CNT_W = 20;
	localparam int WIDE_W = 12;
	localparam int NARROW_W = 8;
	localparam int WIDE_LSB = 0;
	localparam int NARROW_LSB = 12;
	localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
	localparam logic [WIDE_W-1:0] WIDE_ONE = 12'h001;
	localparam logic [NARROW_W-1:0] NARROW_ONE = 8'h01;

	// clock rate and gate timing
	localparam int CLK_FREQ_KHZ = 25000;
	localparam int GATE_BASE_TIME_US = 1000;
	localparam int GATE_BASE_CYC = GATE_BASE_TIME_US * CLK_FREQ_KHZ / 1000;
	localparam int GATE_CNT_W = 22;
	localparam logic [GATE_CNT_W-1:0] GATE_CNT_RESET = 22'h000000;
	localparam logic [GATE_CNT_W-1:0] GATE_CNT_ONE = 22'h000001;

	// gate select codes: 1, 4, 16, 64 ms
	localparam logic [1:0] GSEL_1MS = 2'h0;
	localparam logic [1:0] GSEL_4MS = 2'h1;
	localparam logic [1:0] GSEL_16MS = 2'h2;
	localparam logic [1:0] GSEL_64MS = 2'h3;

	// timer tick of 1 us
	localparam int TIMER_TICK_TIME_NS = 1000;
	localparam int TIMER_TICK_CYC = TIMER_TICK_TIME_NS * CLK_FREQ_KHZ / 1000000;
	localparam int TICK_CNT_W = 5;
	localparam logic [TICK_CNT_W-1:0] TICK_CNT_RESET = 5'h00;
	localparam logic [TICK_CNT_W-1:0] TICK_CNT_ONE = 5'h01;
	localparam logic [TICK_CNT_W-1:0] TICK_LAST = 5'(TIMER_TICK_CYC - 1);

	typedef enum logic [1:0] {
		IFC_MODE_IF = 2'b00,
		IFC_MODE_TIMER = 2'b01,
		IFC_MODE_SPLIT = 2'b10,
		IFC_MODE_SPARE = 2'b11
	} ifc_mode_t;

	typedef enum logic [1:0] {
		IFC_ST_IDLE = 2'b00,
		IFC_ST_RUN = 2'b01,
		IFC_ST_HOLD = 2'b10
	} ifc_state_t;
endpackage : ifc_pkg

// [sim/ifc_pin_source.sv]
`timescale 1ns/1ps
// behavioural square-wave source standing in for the radio and counter pins
module ifc_pin_source (
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic [7:0] i_half,
	output logic o_pin,
	output int o_edges
);
	int ph;
	initial begin
		o_pin = 1'b0;
		o_edges = 0;
		ph = 0;
	end
	// a high half always finishes, so the pin rests low between bursts
	always @(posedge i_clk) begin
		if (i_run || o_pin) begin
			ph = ph + 1;
			if (ph >= int'(i_half)) begin
				ph = 0;
				if (!o_pin) o_edges = o_edges + 1;
				o_pin <= #1 ~o_pin;
			end
		end
	end
endmodule : ifc_pin_source

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import ifc_pkg::*;
	localparam int BASE = 8;
	logic i_clk, i_reset_n, i_if_as_port, i_start, i_stop, i_result_ack;
	logic [1:0] i_mode, i_gate_sel;
	logic if_run, wide_run, narrow_run, if_pin, wide_pin, narrow_pin;
	logic [2:0] pin_d;
	logic [CNT_W-1:0] o_count;
	logic o_done, o_gate_open, o_general_input_port_a;
	int if_e, wide_e, narrow_e, n_errors, comparisons, cycles, n, we, ne;

	ifc_if_counter #(.P_GATE_BASE_CYCLES(BASE)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_intermediate_freq_input(if_pin), .i_wide_counter_pulse_input(wide_pin),
		.i_narrow_counter_pulse_input(narrow_pin), .i_mode(i_mode), .i_gate_sel(i_gate_sel),
		.i_if_as_port(i_if_as_port), .i_start(i_start), .i_stop(i_stop),
		.i_result_ack(i_result_ack), .o_count(o_count), .o_done(o_done),
		.o_gate_open(o_gate_open), .o_general_input_port_a(o_general_input_port_a));
	ifc_pin_source src_if (.i_clk(i_clk), .i_run(if_run), .i_half(8'h02), .o_pin(if_pin),
		.o_edges(if_e));
	ifc_pin_source src_wide (.i_clk(i_clk), .i_run(wide_run), .i_half(8'h02),
		.o_pin(wide_pin), .o_edges(wide_e));
	ifc_pin_source src_narrow (.i_clk(i_clk), .i_run(narrow_run), .i_half(8'h02),
		.o_pin(narrow_pin), .o_edges(narrow_e));

	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// pin history for the port latency check, plus the hang guard
	always @(posedge i_clk) begin
		pin_d <= {pin_d[1:0], if_pin};
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end

	task automatic check(input string name, input logic [CNT_W-1:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask : tick
	// start takes effect on the edge after it is raised
	task automatic go(input logic [1:0] mode, sel);
		i_mode = mode;
		i_gate_sel = sel;
		i_start = 1'b1;
		tick(1);
		i_start = 1'b0;
		check("open", o_gate_open, 1);
		check("clear", o_count, 0);
		check("done_clr", o_done, 0);
	endtask : go
	task automatic halt();
		i_stop = 1'b1;
		tick(1);
		i_stop = 1'b0;
		check("stop_done", o_done, 1);
	endtask : halt
	task automatic wait_close(input int first);
		n = first;
		// n counts open cycles seen so far; the closing edge adds none
		while (o_gate_open === 1'b1 && n < 5000) begin
			tick(1);
			if (o_gate_open === 1'b1) n++;
		end
	endtask : wait_close
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results

	initial begin
		{i_if_as_port, i_start, i_stop, i_result_ack, if_run, wide_run, narrow_run} = '0;
		{i_mode, i_gate_sel} = '0;
		pin_d = '0;
		{n_errors, comparisons, cycles} = '0;
		i_reset_n = 1'b0;
		tick(2);
		i_reset_n = 1'b1;
		tick(1);
		check("rst_cnt", o_count, 0);
		check("rst_flags", {o_done, o_gate_open}, 0);
		if_run = 1'b1;
		tick(20);
		// every gate length, each start back to back with the last close
		for (int s = 0; s < 4; s++) begin
			go(IFC_MODE_IF, 2'(s));
			wait_close(1);
			check("gate_len", 20'(n), 20'(BASE << (2 * s)));
			check("if_count", o_count, 20'((BASE << (2 * s)) / 4));
			check("done", o_done, 1);
		end
		tick(3);
		check("held", o_count, 20'(BASE * 16));
		i_result_ack = 1'b1;
		tick(1);
		i_result_ack = 1'b0;
		check("ack", o_done, 0);
		// a second start while the gate is open must be ignored
		go(IFC_MODE_IF, GSEL_1MS);
		// one idle cycle so start is not lowered and raised in one step
		tick(1);
		i_start = 1'b1;
		tick(1);
		i_start = 1'b0;
		wait_close(3);
		check("refused_len", 20'(n), 20'(BASE));
		check("refused_cnt", o_count, 20'(BASE / 4));
		// pin as plain input: no counting, level follows the pin
		i_if_as_port = 1'b1;
		go(IFC_MODE_IF, GSEL_4MS);
		for (int k = 0; k < 8; k++) begin
			check("port", o_general_input_port_a, pin_d[2]);
			tick(1);
		end
		wait_close(9);
		check("port_cnt", o_count, 0);
		i_if_as_port = 1'b0;
		// timer: one count per 25 clocks
		go(IFC_MODE_TIMER, GSEL_64MS);
		tick(105);
		halt();
		check("timer", o_count, 20'h00004);
		// spare mode holds the counter
		go(IFC_MODE_SPARE, GSEL_1MS);
		tick(20);
		halt();
		check("spare", o_count, 0);
		// split: two pins, narrow field wraps on its own
		if_run = 1'b0;
		go(IFC_MODE_SPLIT, GSEL_1MS);
		tick(4);
		we = wide_e;
		ne = narrow_e;
		wide_run = 1'b1;
		narrow_run = 1'b1;
		tick(40);
		wide_run = 1'b0;
		tick(1000);
		narrow_run = 1'b0;
		tick(10);
		check("split_open", o_gate_open, 1);
		halt();
		check("split", o_count, {8'(narrow_e - ne), 12'(wide_e - we)});
		results();
	end
endmodule : tb_top
